// [pkg/rcl_pkg.sv]
// rcl_pkg: constants and types for the reset and configuration load sequencer
package rcl_pkg;
   // power-up delay timer: 5-bit counter on the internal rc oscillator
   localparam int PDT_WIDTH = 5;
   localparam logic [4:0] PDT_TERMINAL = 5'h1f;
   // rc oscillator period in ns and ref_clk period in ns
   localparam int RC_PERIOD_NS = 32000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int RC_HALF_CYCLES = (RC_PERIOD_NS / CLK_PERIOD_NS) / 2;
   localparam int RC_DIV_WIDTH = 12;
   // program memory vectors
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] HIGH_INT_VECTOR = 16'h0008;
   localparam logic [15:0] LOW_INT_VECTOR = 16'h0018;
   // configuration area: last eight bytes of program memory
   localparam logic [15:0] CFG_BASE_16K = 16'h3ff8;
   localparam logic [15:0] CFG_BASE_32K = 16'h7ff8;
   localparam logic [15:0] CFG_BASE_64K = 16'hfff8;
   localparam int CFG_BYTES = 8;
   localparam logic [2:0] CFG_LAST_BYTE = 3'h7;
   // memory size selector codes
   localparam logic [1:0] MEM_16K = 2'h0;
   localparam logic [1:0] MEM_32K = 2'h1;
   localparam logic [1:0] MEM_64K = 2'h2;
   // config mismatch flag position in the reset control register
   localparam int MISMATCH_FLAG_BIT = 5;
   localparam logic MISMATCH_FLAG_RESET = 1'b1;
   // sequencer states
   typedef enum logic [2:0] {
      RCL_POR = 3'b000,
      RCL_DELAY = 3'b001,
      RCL_LOAD = 3'b010,
      RCL_WAIT_CLEAR = 3'b011,
      RCL_RUN = 3'b100
   } rcl_state_t;
endpackage : rcl_pkg

// [rtl/rcl_cfg_shadow.sv]
// rcl_cfg_shadow: configuration registers with complementary shadow copies
`timescale 1ns/10ps
`default_nettype none
module rcl_cfg_shadow
   import rcl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstN,
   input wire logic loadEn,
   input wire logic [2:0] loadIdx,
   input wire logic [7:0] loadByte,
   input wire logic checkEn,
   input wire logic [CFG_BYTES-1:0] upsetMask,
   output logic [8*CFG_BYTES-1:0] cfgWords,
   output logic mismatch
);
   logic [7:0] cfg_r [CFG_BYTES];
   logic [7:0] shadow_r [CFG_BYTES];
   logic [CFG_BYTES-1:0] diff;
   ////////////////////////////////////////////////////////////////////////
   // one byte lane per generate pass; upsetMask models a corrupting event
   genvar g;
   generate
      for (g = 0; g < CFG_BYTES; g++)
      begin : g_lane
         always_ff @(posedge ref_clk or negedge rstN)
         begin
            if (!rstN)
            begin
               cfg_r[g] <= 8'h00;
               shadow_r[g] <= 8'hff;
            end
            else if (loadEn && loadIdx == 3'(g))
            begin
               cfg_r[g] <= loadByte;
               shadow_r[g] <= ~loadByte;
            end
            else if (upsetMask[g])
               cfg_r[g] <= cfg_r[g] ^ 8'h01;
         end
         // byte and shadow must be exact complements
         assign diff[g] = (cfg_r[g] != ~shadow_r[g]);
         assign cfgWords[8*g +: 8] = cfg_r[g];
      end
   endgenerate
   // any disagreeing lane flags a mismatch while checking
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         mismatch <= 1'b0;
      else
         mismatch <= checkEn & (|diff);
   end
endmodule : rcl_cfg_shadow
`default_nettype wire

// [rtl/rcl_rc_tick.sv]
// rcl_rc_tick: internal rc oscillator model producing one tick per rc period
`timescale 1ns/10ps
`default_nettype none
module rcl_rc_tick
   import rcl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstN,
   output logic rcTick
);
   logic [RC_DIV_WIDTH-1:0] divCnt_r;
   logic phase_r;
   wire divDone = (divCnt_r == RC_DIV_WIDTH'(RC_HALF_CYCLES - 1));
   ////////////////////////////////////////////////////////////////////////
   // free running divider, tick on each full rc period
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         divCnt_r <= '0;
         phase_r <= 1'b0;
         rcTick <= 1'b0;
      end
      else
      begin
         divCnt_r <= divDone ? '0 : divCnt_r + 1'b1;
         if (divDone)
            phase_r <= ~phase_r;
         rcTick <= divDone & phase_r;
      end
   end
endmodule : rcl_rc_tick
`default_nettype wire

// [rtl/rcl_sequencer.sv]
// rcl_sequencer: reset release, power-up delay and configuration load
`timescale 1ns/10ps
`default_nettype none
//
// Summary of operation
// - compare config registers with shadows only while running
// - mismatch forces reset without software
// - mismatch clears flag bit five only
// - mismatch acts like other hard resets
// - a hard reset while running reloads configuration words
// - power-up delay timer always enabled
// - delay timer is 5-bit rc counter
// - delay is 32 rc periods, about 1ms
// - device held in reset while counting
// - timer starts after power-on pulse
// - late master clear release starts immediately
// - master clear low resets the device
// - program counter loads 0000h on reset
// - interrupt vectors at 0008h and 0018h
// - top four words copied into config
// - config bytes stored in ascending order
// - config area is last eight bytes
module rcl_sequencer
   import rcl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic porPulse,
   input wire logic masterClearPinN,
   input wire logic softResetReq,
   input wire logic watchdogTimeout,
   input wire logic stackEventReset,
   input wire logic [1:0] memSize,
   input wire logic [7:0] progMemData,
   input wire logic [CFG_BYTES-1:0] upsetMask,
   input wire logic intHighReq,
   input wire logic intLowReq,
   output logic [15:0] progMemAddr,
   output logic progMemRead,
   output logic coreResetN,
   output logic [15:0] pcLoadValue,
   output logic pcLoad,
   output logic configMismatchFlag,
   output logic [8*CFG_BYTES-1:0] cfgWords
);
   ////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   logic rstSync1_r;
   logic rstSync2_r;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstSync1_r <= 1'b0;
         rstSync2_r <= 1'b0;
      end
      else
      begin
         rstSync1_r <= 1'b1;
         rstSync2_r <= rstSync1_r;
      end
   end
   wire rstN = rstSync2_r;

   ////////////////////////////////////////////////////////////////////////
   // internal rc oscillator tick and configuration storage
   logic rcTick;
   logic mismatch;
   logic checkEn;
   logic loadEn_r;
   logic [2:0] loadIdx_r;
   logic [2:0] byteIdx_r;
   rcl_rc_tick u_rc (
      .ref_clk(ref_clk),
      .rstN(rstN),
      .rcTick(rcTick)
   );
   rcl_cfg_shadow u_cfg (
      .ref_clk(ref_clk),
      .rstN(rstN),
      .loadEn(loadEn_r),
      .loadIdx(loadIdx_r),
      .loadByte(progMemData),
      .checkEn(checkEn),
      .upsetMask(upsetMask),
      .cfgWords(cfgWords),
      .mismatch(mismatch)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode of the configuration area base per memory size
   function automatic logic [15:0] cfgBase(input logic [1:0] sel);
      unique case (sel)
         MEM_16K: cfgBase = CFG_BASE_16K;
         MEM_32K: cfgBase = CFG_BASE_32K;
         default: cfgBase = CFG_BASE_64K;
      endcase
   endfunction : cfgBase

   rcl_state_t state_r;
   rcl_state_t state_nxt;
   logic [PDT_WIDTH-1:0] pdtCount_r;
   logic corePc_r;

   // hard reset sources, the mismatch among them
   wire hardReset = !masterClearPinN | softResetReq | watchdogTimeout | stackEventReset | mismatch;
   // done on the tick after terminal count: 32 rc periods in all
   wire pdtDone = (pdtCount_r == PDT_TERMINAL) && rcTick;
   wire loadLast = (byteIdx_r == CFG_LAST_BYTE);
   // ascending byte addresses from the top eight bytes
   wire [15:0] cfgAddr = cfgBase(memSize) + {13'h0000, byteIdx_r};
   assign checkEn = (state_r == RCL_RUN);

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         RCL_POR:
            if (!porPulse)
               state_nxt = RCL_DELAY;
         RCL_DELAY:
            if (pdtDone)
               state_nxt = RCL_LOAD;
         RCL_LOAD:
            if (loadLast && loadEn_r)
               state_nxt = RCL_WAIT_CLEAR;
         RCL_WAIT_CLEAR:
            if (!hardReset)
               state_nxt = RCL_RUN;
         RCL_RUN:
            if (hardReset)
               state_nxt = RCL_LOAD;
         default:
            state_nxt = RCL_POR;
      endcase
      if (porPulse)
         state_nxt = RCL_POR;
   end

   ////////////////////////////////////////////////////////////////////////
   // state, delay counter and load stepping
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_r <= RCL_POR;
         pdtCount_r <= '0;
         byteIdx_r <= '0;
         loadEn_r <= 1'b0;
         loadIdx_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         // counts rc ticks in RCL_DELAY, cleared in other states, no option disables it
         if (state_r != RCL_DELAY)
            pdtCount_r <= '0;
         else if (rcTick && !pdtDone)
            pdtCount_r <= pdtCount_r + 1'b1;
         // read address issued one cycle before the byte is captured
         loadEn_r <= (state_r == RCL_LOAD) && !loadEn_r;
         loadIdx_r <= byteIdx_r;
         if (state_r != RCL_LOAD)
            byteIdx_r <= '0;
         else if (loadEn_r && !loadLast)
            byteIdx_r <= byteIdx_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         progMemAddr <= '0;
         progMemRead <= 1'b0;
         coreResetN <= 1'b0;
         pcLoadValue <= RESET_VECTOR;
         pcLoad <= 1'b0;
         corePc_r <= 1'b0;
         configMismatchFlag <= MISMATCH_FLAG_RESET;
      end
      else
      begin
         progMemAddr <= cfgAddr;
         // one read per byte, in the cycle before its capture edge
         progMemRead <= (state_nxt == RCL_LOAD) && (state_r == RCL_LOAD) && !loadEn_r;
         coreResetN <= (state_nxt == RCL_RUN);
         corePc_r <= (state_nxt == RCL_RUN);
         // flag cleared only by a mismatch event, sticky otherwise
         if (mismatch)
            configMismatchFlag <= 1'b0;
         // vector select: reset vector wins over interrupts
         pcLoad <= 1'b0;
         if (state_nxt != RCL_RUN)
         begin
            pcLoadValue <= RESET_VECTOR;
            pcLoad <= 1'b1;
         end
         else if (corePc_r && intHighReq)
         begin
            pcLoadValue <= HIGH_INT_VECTOR;
            pcLoad <= 1'b1;
         end
         else if (corePc_r && intLowReq)
         begin
            pcLoadValue <= LOW_INT_VECTOR;
            pcLoad <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   property p_mismatch_resets;
      @(posedge ref_clk) disable iff (!rstN)
      mismatch |=> !coreResetN;
   endproperty
   a_mismatch_resets: assert property (p_mismatch_resets) else $error("mismatch did not reset core");

   property p_flag_clears;
      @(posedge ref_clk) disable iff (!rstN)
      mismatch |=> !configMismatchFlag;
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("mismatch flag not cleared");

   property p_flag_no_set;
      @(posedge ref_clk) disable iff (!rstN)
      !configMismatchFlag |=> !configMismatchFlag;
   endproperty
   a_flag_no_set: assert property (p_flag_no_set) else $error("mismatch flag changed by other source");

   property p_master_clear_pin_resets;
      @(posedge ref_clk) disable iff (!rstN)
      !masterClearPinN |=> !coreResetN;
   endproperty
   a_master_clear_pin_resets: assert property (p_master_clear_pin_resets) else $error("master clear low did not hold reset");

   property p_held_in_delay;
      @(posedge ref_clk) disable iff (!rstN)
      (state_r == RCL_DELAY) |-> !coreResetN;
   endproperty
   a_held_in_delay: assert property (p_held_in_delay) else $error("core released during delay");

   property p_no_count_in_por;
      @(posedge ref_clk) disable iff (!rstN)
      porPulse |=> (pdtCount_r == '0);
   endproperty
   a_no_count_in_por: assert property (p_no_count_in_por) else $error("delay counted during power-on pulse");

   property p_reset_vector;
      @(posedge ref_clk) disable iff (!rstN)
      !coreResetN |-> (pcLoadValue == RESET_VECTOR);
   endproperty
   a_reset_vector: assert property (p_reset_vector) else $error("reset vector wrong");

   property p_hard_reset_reload;
      @(posedge ref_clk) disable iff (!rstN)
      (state_r == RCL_RUN) && hardReset |=> (state_r == RCL_LOAD) ##[1:24] (state_r != RCL_LOAD);
   endproperty
   a_hard_reset_reload: assert property (p_hard_reset_reload) else $error("no reload after hard reset");

   sequence s_wait_ready;
      (state_r == RCL_WAIT_CLEAR) && masterClearPinN && !hardReset;
   endsequence
   property p_late_master_clear_pin_start;
      @(posedge ref_clk) disable iff (!rstN)
      s_wait_ready |=> coreResetN;
   endproperty
   a_late_master_clear_pin_start: assert property (p_late_master_clear_pin_start) else $error("late master clear did not start core");

   property p_cfg_addr_range;
      @(posedge ref_clk) disable iff (!rstN)
      progMemRead |-> (progMemAddr[2:0] <= CFG_LAST_BYTE) && (progMemAddr[15:3] == cfgBase(memSize) >> 3);
   endproperty
   a_cfg_addr_range: assert property (p_cfg_addr_range) else $error("config read outside top eight bytes");

   // delay counter steps by one on each rc tick
   property p_pdt_step;
      @(posedge ref_clk) disable iff (!rstN)
      (state_r == RCL_DELAY) && rcTick && !pdtDone |=> (pdtCount_r == PDT_WIDTH'($past(pdtCount_r) + 1'b1));
   endproperty
   a_pdt_step: assert property (p_pdt_step) else $error("delay counter did not step");

   // nothing but terminal count or power-on ends the delay
   property p_delay_kept;
      @(posedge ref_clk) disable iff (!rstN)
      (state_r == RCL_DELAY) && !pdtDone && !porPulse |=> (state_r == RCL_DELAY);
   endproperty
   a_delay_kept: assert property (p_delay_kept) else $error("delay left early");

   // interrupt vectors while running, high before low
   property p_high_vector;
      @(posedge ref_clk) disable iff (!rstN)
      (state_nxt == RCL_RUN) && corePc_r && intHighReq |=> pcLoad && (pcLoadValue == HIGH_INT_VECTOR);
   endproperty
   a_high_vector: assert property (p_high_vector) else $error("high vector not loaded");

   property p_low_vector;
      @(posedge ref_clk) disable iff (!rstN)
      (state_nxt == RCL_RUN) && corePc_r && !intHighReq && intLowReq |=> pcLoad && (pcLoadValue == LOW_INT_VECTOR);
   endproperty
   a_low_vector: assert property (p_low_vector) else $error("low vector not loaded");

   // each read is captured into the lane that its address names
   sequence s_byte_read;
      progMemRead;
   endsequence
   property p_read_capture;
      @(posedge ref_clk) disable iff (!rstN)
      s_byte_read |-> loadEn_r && (loadIdx_r == progMemAddr[2:0]);
   endproperty
   a_read_capture: assert property (p_read_capture) else $error("read byte not captured in its lane");

   // byte index climbs by one after each capture but the last
   property p_ascending;
      @(posedge ref_clk) disable iff (!rstN)
      (state_r == RCL_LOAD) && loadEn_r && !loadLast |=> (byteIdx_r == 3'($past(byteIdx_r) + 1'b1));
   endproperty
   a_ascending: assert property (p_ascending) else $error("config bytes not ascending");

   // core stays held until the wait state has been passed
   property p_release_gate;
      @(posedge ref_clk) disable iff (!rstN)
      (state_r != RCL_RUN) && (state_r != RCL_WAIT_CLEAR) |=> !coreResetN;
   endproperty
   a_release_gate: assert property (p_release_gate) else $error("core released too early");
endmodule : rcl_sequencer
`default_nettype wire

// [tb/rcl_pm_model.sv]
// rcl_pm_model: program memory and board master clear model
`timescale 1ns/10ps
`default_nettype none
module rcl_pm_model
(
   input wire logic ref_clk,
   input wire logic [15:0] progMemAddr,
   input wire logic progMemRead,
   input wire logic clearHold,
   output logic [7:0] progMemData,
   output logic masterClearPinN
);
   ////////////////////////////////////////////////////////////////////////////
   // board switch pulls the pin low while held
   assign masterClearPinN = ~clearHold;
   // byte answers the read of this cycle; without a read it shows the inverse
   wire logic [7:0] pmByte = progMemAddr[15:8] + progMemAddr[7:0];
   assign progMemData = progMemRead ? pmByte : ~pmByte;
endmodule : rcl_pm_model
`default_nettype wire

// [tb/tb.sv]
// tb: self-checking bench for the reset and configuration load sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rcl_pkg::*;
   logic ref_clk, rst_n, porPulse, softResetReq, watchdogTimeout, stackEventReset;
   logic intHighReq, intLowReq, clearHold, progMemRead, coreResetN, pcLoad, configMismatchFlag;
   logic [1:0] memSize;
   logic [7:0] upsetMask, progMemData;
   logic [15:0] progMemAddr, pcLoadValue, firstAddr, lastAddr;
   logic [63:0] cfgWords;
   wire logic masterClearPinN;
   int n_fail, compares, nRd, ordErr, k, hi;
   // rows: memory size, reset source, high and low requests, area base, vector
   logic [37:0] rows [4] = '{{2'h0, 2'h0, 2'b10, 16'h3ff8, 16'h0008}, {2'h1, 2'h1, 2'b01, 16'h7ff8, 16'h0018},
      {2'h2, 2'h2, 2'b11, 16'hfff8, 16'h0008}, {2'h3, 2'h3, 2'b01, 16'hfff8, 16'h0018}};

   rcl_sequencer i_rcl_sequencer (.ref_clk(ref_clk), .rst_n(rst_n), .porPulse(porPulse),
      .masterClearPinN(masterClearPinN), .softResetReq(softResetReq), .watchdogTimeout(watchdogTimeout),
      .stackEventReset(stackEventReset), .memSize(memSize), .progMemData(progMemData), .upsetMask(upsetMask),
      .intHighReq(intHighReq), .intLowReq(intLowReq), .progMemAddr(progMemAddr), .progMemRead(progMemRead),
      .coreResetN(coreResetN), .pcLoadValue(pcLoadValue), .pcLoad(pcLoad),
      .configMismatchFlag(configMismatchFlag), .cfgWords(cfgWords));
   rcl_pm_model i_rcl_pm_model (.ref_clk(ref_clk), .progMemAddr(progMemAddr), .progMemRead(progMemRead),
      .clearHold(clearHold), .progMemData(progMemData), .masterClearPinN(masterClearPinN));

   ////////////////////////////////////////////////////////////////////////////
   // clock and read monitor: first address, count and ascending order
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      if (progMemRead === 1'b1)
      begin
         if (nRd == 0)
            firstAddr = progMemAddr;
         else if (progMemAddr !== lastAddr + 16'h0001)
            ordErr++;
         lastAddr = progMemAddr;
         nRd++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers: report, compare, wait
   task automatic fail(input string m);
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
   endtask : fail
   task automatic chkBit(input logic g, input logic e, input string m);
      compares++;
      if (g !== e) fail(m);
   endtask : chkBit
   task automatic chkWord(input logic [15:0] g, input logic [15:0] e, input string m);
      compares++;
      if (g !== e) fail(m);
   endtask : chkWord
   task automatic chkCfg(input logic [15:0] b);
      logic [63:0] v;
      for (int i = 0; i < 8; i++) v[8*i+:8] = b[15:8] + b[7:0] + 8'(i);
      compares++;
      if (cfgWords !== v) fail("config words");
      chkWord(firstAddr, b, "first address");
      chkWord(16'(nRd), 16'h0008, "byte count");
      chkWord(16'(ordErr), 16'h0000, "address order");
   endtask : chkCfg
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic waitCore(input logic lvl, input int lim);
      int j;
      j = 0;
      while (coreResetN !== lvl && j < lim)
      begin
         cyc(1);
         j++;
      end
      chkBit(coreResetN, lvl, "core reset level");
   endtask : waitCore
   task automatic hard(input logic [1:0] s);
      nRd = 0;
      case (s)
         2'h0: clearHold = 1'b1;
         2'h1: softResetReq = 1'b1;
         2'h2: watchdogTimeout = 1'b1;
         default: stackEventReset = 1'b1;
      endcase
      cyc(2);
      {clearHold, softResetReq, watchdogTimeout, stackEventReset} = 4'h0;
   endtask : hard
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////
   // watchdog beyond the power-up delay plus the rows
   initial
   begin
      #1600000;
      fail("timeout");
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {rst_n, softResetReq, watchdogTimeout, stackEventReset, intHighReq, intLowReq} = 6'h0;
      {porPulse, clearHold, memSize, upsetMask, nRd, ordErr, hi} = {1'b1, 1'b1, MEM_32K, 8'h00, 96'h0};
      cyc(10);
      chkBit(coreResetN, 1'b0, "core in reset");
      chkWord(pcLoadValue, RESET_VECTOR, "reset vector");
      chkBit(configMismatchFlag, MISMATCH_FLAG_RESET, "flag reset");
      chkBit(progMemRead, 1'b0, "no read in reset");
      rst_n = 1'b1;
      cyc(8000);
      porPulse = 1'b0;
      k = 0;
      while (nRd == 0 && k < 140000)
      begin
         cyc(1);
         k++;
         hi = hi | int'(coreResetN !== 1'b0);
      end
      chkBit(k >= 124000 && k <= 132000, 1'b1, "delay length");
      chkBit(hi == 0, 1'b1, "held during delay");
      cyc(2000);
      chkBit(coreResetN, 1'b0, "clear held low");
      chkCfg(16'h7ff8);
      clearHold = 1'b0;
      waitCore(1'b1, 3);
      $display("power-up test done");
      for (int i = 0; i < 4; i++)
      begin
         memSize = rows[i][37:36];
         {intHighReq, intLowReq} = rows[i][33:32];
         hard(rows[i][35:34]);
         chkBit(coreResetN, 1'b0, "hard reset taken");
         chkWord(pcLoadValue, RESET_VECTOR, "vector in reset");
         waitCore(1'b1, 200);
         cyc(2);
         chkCfg(rows[i][31:16]);
         chkWord(pcLoadValue, rows[i][15:0], "interrupt vector");
         chkBit(pcLoad, 1'b1, "vector load");
         chkBit(configMismatchFlag, 1'b1, "flag kept");
         {intHighReq, intLowReq} = 2'b00;
         cyc(4);
         $display("row %0d done", i);
      end
      nRd = 0;
      upsetMask = 8'h04;
      cyc(1);
      upsetMask = 8'h00;
      waitCore(1'b0, 6);
      chkBit(configMismatchFlag, 1'b0, "flag cleared");
      waitCore(1'b1, 200);
      cyc(1);
      chkCfg(16'hfff8);
      hard(2'h1);
      waitCore(1'b1, 200);
      chkBit(configMismatchFlag, 1'b0, "flag unchanged");
      $display("mismatch test done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
